//--- logic/eat_top.sv
`timescale 1ns/100ps
`include "eat_map.svh"
module eat_top #(
  parameter int CW = 16
) (
  input  wire logic              core_clk,
  input  wire logic              srst,
  input  wire eat_pkg::eat_bus_t bus,
  output logic          [15:0]   rdata,
  input  wire eat_pkg::eat_pins_t pins,
  input  wire logic              sleep,
  input  wire logic              idle,
  output eat_pkg::eat_own_t      own,
  output logic                   direction_status,
  output logic                   irq
);
  import eat_pkg::*;

  // ****************************************
  // input synchronisers
  // ****************************************
  eat_pins_t pins_s;
  logic [2:0] sync_o;

  eat_sync #(.WIDTH(3)) u_sync (
    .core_clk (core_clk),
    .srst     (srst),
    .async_in ({pins.phase_a, pins.phase_b, pins.index}),
    .sync_out (sync_o)
  );
  assign pins_s = eat_pins_t'(sync_o);

  // ****************************************
  // registers
  // ****************************************
  logic [15:0] ctrl_q;
  logic [15:0] filt_q;
  logic [CW-1:0] pos_q;
  logic [CW-1:0] max_q;
  logic        iflag_q;
  logic        ien_q;
  logic        cerr_q;
  eat_mode_t   mode;
  logic        halted;
  logic        timer_m;
  logic        match_m;
  logic        index_m;
  logic        enabled;

  assign mode    = eat_mode_t'(ctrl_q[`EAT_B_MODE_HI:`EAT_B_MODE_LO]);
  assign timer_m = (mode == EAT_MODE_TIMER);
  assign match_m = (mode == EAT_MODE_MAT5) || (mode == EAT_MODE_MAT7);
  assign index_m = (mode == EAT_MODE_IDX4) || (mode == EAT_MODE_IDX6);
  assign enabled = timer_m || match_m || index_m;
  assign halted  = sleep || (idle && ctrl_q[`EAT_B_SIDL]);

  // ****************************************
  // pin history and edges
  // ****************************************
  logic a_q;
  logic b_q;
  logic x_q;
  logic a_rise;
  logic a_fall;
  logic a_chg;
  logic b_chg;
  logic x_rise;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      a_q <= 1'b0;
      b_q <= 1'b0;
      x_q <= 1'b0;
    end else if (!halted) begin
      a_q <= pins_s.phase_a;
      b_q <= pins_s.phase_b;
      x_q <= pins_s.index;
    end
  end

  assign a_rise = !halted && pins_s.phase_a && !a_q;
  assign a_fall = !halted && !pins_s.phase_a && a_q;
  assign a_chg  = !halted && (pins_s.phase_a != a_q);
  assign b_chg  = !halted && (pins_s.phase_b != b_q);
  assign x_rise = !halted && pins_s.index && !x_q;

  // ****************************************
  // timer step and direction
  // ****************************************
  logic t_up;
  logic t_step;
  logic t_conflict;

  assign t_up = ctrl_q[`EAT_B_DIRSRC] ? pins_s.phase_b : ctrl_q[`EAT_B_DIR];
  assign t_conflict = ctrl_q[`EAT_B_GATE] && ctrl_q[`EAT_B_CLKSRC];

  always_comb begin
    t_step = 1'b0;
    if (timer_m && !halted && !t_conflict) begin
      if (ctrl_q[`EAT_B_CLKSRC])
        t_step = a_rise;
      else if (ctrl_q[`EAT_B_GATE])
        t_step = pins_s.phase_a;
      else
        t_step = 1'b1;
    end
  end

  // ****************************************
  // encoder decode (x4)
  // ****************************************
  logic e_step;
  logic e_up;
  logic dir_q;

  assign e_step = (match_m || index_m) && (a_chg ^ b_chg);
  assign e_up   = a_chg ? (pins_s.phase_a != pins_s.phase_b)
                        : (pins_s.phase_a == pins_s.phase_b);

  always_ff @(posedge core_clk) begin
    if (srst)
      dir_q <= 1'b0;
    else if (e_step)
      dir_q <= e_up;
  end

  // ****************************************
  // position counter
  // ****************************************
  logic t_match;
  logic roll;
  logic idx_hit;
  logic cerr_hit;
  logic ev_timer;
  logic ev_gate;
  logic ev_match;
  logic ev_index;
  logic ev_cerr;
  logic sw_pos;

  assign sw_pos  = bus.wr && (bus.addr == `EAT_IDX_POS);
  assign t_match = t_step && (pos_q == max_q);
  assign roll    = e_step && (e_up ? (pos_q == max_q) : (pos_q == '0));
  assign idx_hit = index_m && x_rise;
  assign cerr_hit = index_m && e_step &&
                    (e_up ? (pos_q == max_q) : (pos_q == '0));

  always_ff @(posedge core_clk) begin
    if (srst)
      pos_q <= `EAT_RST_POS;
    else if (sw_pos)
      pos_q <= bus.wdata[CW-1:0];
    else if (t_match)
      pos_q <= '0;
    else if (t_step)
      pos_q <= t_up ? pos_q + 1'b1 : pos_q - 1'b1;
    else if (idx_hit)
      pos_q <= dir_q ? '0 : max_q;
    else if (roll)
      pos_q <= e_up ? '0 : max_q;
    else if (e_step)
      pos_q <= e_up ? pos_q + 1'b1 : pos_q - 1'b1;
  end

  // ****************************************
  // events
  // ****************************************
  // period and gate fall events
  assign ev_timer = timer_m && t_match;
  assign ev_gate  = timer_m && ctrl_q[`EAT_B_GATE] && a_fall;
  assign ev_match = match_m && roll;
  assign ev_index = idx_hit;
  assign ev_cerr  = cerr_hit && !cerr_q && !filt_q[`EAT_B_COUNT_ERROR_IRQ_DISABLE];

  always_ff @(posedge core_clk) begin
    if (srst)
      cerr_q <= 1'b0;
    else if (cerr_hit)
      cerr_q <= 1'b1;
    else if (bus.wr && bus.addr == `EAT_IDX_CTRL)
      cerr_q <= bus.wdata[`EAT_B_CERR];
  end

  always_ff @(posedge core_clk) begin
    if (srst)
      iflag_q <= 1'b0;
    else if (ev_timer || ev_gate || ev_match || ev_index || ev_cerr ||
             (timer_m && t_conflict && !halted))
      iflag_q <= 1'b1;
    else if (bus.wr && bus.addr == `EAT_IDX_IRQ)
      iflag_q <= bus.wdata[`EAT_B_IFLAG];
  end

  assign irq = iflag_q && ien_q;

  // ****************************************
  // control registers
  // ****************************************
  // reset to initial state
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl_q <= `EAT_RST_CTRL;
      filt_q <= `EAT_RST_FILT;
      max_q  <= `EAT_RST_MAX;
      ien_q  <= 1'b0;
    end else if (bus.wr) begin
      unique case (bus.addr)
        `EAT_IDX_CTRL: ctrl_q <= bus.wdata & 16'h6FFF;
        `EAT_IDX_FILT: filt_q <= bus.wdata & 16'h01FF;
        `EAT_IDX_MAX:  max_q  <= bus.wdata[CW-1:0];
        `EAT_IDX_IRQ:  ien_q  <= bus.wdata[`EAT_B_IEN];
        default: ;
      endcase
    end
  end

  // ****************************************
  // read port
  // ****************************************
  logic [15:0] ctrl_rd;

  always_comb begin
    ctrl_rd = ctrl_q;
    ctrl_rd[`EAT_B_CERR]  = cerr_q;
    ctrl_rd[`EAT_B_INDEX] = pins_s.index;
    if (match_m || index_m)
      ctrl_rd[`EAT_B_DIR] = dir_q;
  end

  always_ff @(posedge core_clk) begin
    if (srst)
      rdata <= 16'h0000;
    else if (bus.rd) begin
      unique case (bus.addr)
        `EAT_IDX_CTRL: rdata <= ctrl_rd;
        `EAT_IDX_FILT: rdata <= filt_q;
        `EAT_IDX_POS:  rdata <= 16'(pos_q);
        `EAT_IDX_MAX:  rdata <= 16'(max_q);
        `EAT_IDX_IRQ:  rdata <= {7'h00, iflag_q, 7'h00, ien_q};
        default:       rdata <= 16'h0000;
      endcase
    end else
      rdata <= 16'h0000;
  end

  // ****************************************
  // pin ownership
  // ****************************************
  // enabled module owns pins
  // phase A, phase B and index use per mode
  always_ff @(posedge core_clk) begin
    if (srst) begin
      own              <= '0;
      direction_status <= 1'b0;
    end else begin
      own.phase_a_own <= match_m || index_m ||
                         (timer_m && (ctrl_q[`EAT_B_GATE] ||
                                      ctrl_q[`EAT_B_CLKSRC]));
      own.phase_b_own <= match_m || index_m ||
                         (timer_m && ctrl_q[`EAT_B_DIRSRC]);
      own.index_own   <= index_m;
      own.dir_own     <= (match_m || index_m) && ctrl_q[`EAT_B_DOUT];
      direction_status <= dir_q;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  timer_wrap_a: assert property (@(posedge core_clk) disable iff (srst)
    t_match && !sw_pos |=> pos_q == '0)
    else $error("timer did not clear on match");
  timer_down_a: assert property (@(posedge core_clk) disable iff (srst)
    t_step && !t_match && !t_up && !sw_pos |=> pos_q == $past(pos_q) - 1'b1)
    else $error("timer down step wrong");
  // a halted module raises no conflict event, so the property requires the module not halted
  conflict_hold_a: assert property (@(posedge core_clk)
    disable iff (srst)
    timer_m && t_conflict && !halted && !sw_pos |=>
    pos_q == $past(pos_q) && iflag_q)
    else $error("conflict did not hold or flag");
  flag_set_a: assert property (@(posedge core_clk) disable iff (srst)
    ev_timer || ev_match || ev_index |=> iflag_q)
    else $error("event lost");
  irq_gate_a: assert property (@(posedge core_clk) disable iff (srst)
    irq |-> iflag_q && ien_q)
    else $error("irq without enable");
  flag_clear_a: assert property (@(posedge core_clk)
    disable iff (srst)
    $fell(iflag_q) |-> $past(bus.wr && bus.addr == `EAT_IDX_IRQ))
    else $error("flag cleared without software write");
  off_pins_a: assert property (@(posedge core_clk) disable iff (srst)
    !enabled ##1 !enabled |-> own == '0)
    else $error("off mode owns pins");
  halt_hold_a: assert property (@(posedge core_clk) disable iff (srst)
    halted && !sw_pos |=> pos_q == $past(pos_q))
    else $error("counter moved while halted");
  dir_pin_a: assert property (@(posedge core_clk) disable iff (srst)
    own.dir_own |-> $past(match_m || index_m))
    else $error("direction pin in wrong mode");
  reset_val_a: assert property (@(posedge core_clk)
    srst |=> max_q == '1 && pos_q == '0 && ctrl_q == 16'h0000)
    else $error("bad reset values");

  timer_wrap_c: cover property (@(posedge core_clk) disable iff (srst)
    ev_timer);
  enc_roll_c: cover property (@(posedge core_clk) disable iff (srst)
    ev_match);
  index_c: cover property (@(posedge core_clk) disable iff (srst)
    ev_index);
  gate_fall_c: cover property (@(posedge core_clk) disable iff (srst)
    ev_gate);
endmodule // eat_top

//--- logic/eat_map.svh
`ifndef EAT_MAP_SVH
`define EAT_MAP_SVH
// register indices, byte address = 4 * index
`define EAT_IDX_CTRL      4'h0
`define EAT_IDX_FILT      4'h1
`define EAT_IDX_POS       4'h2
`define EAT_IDX_MAX       4'h3
`define EAT_IDX_IRQ       4'h4
// control register fields
`define EAT_B_DIRSRC      0
`define EAT_B_CLKSRC      1
`define EAT_B_GATE        5
`define EAT_B_DOUT        6
`define EAT_B_MODE_LO     8
`define EAT_B_MODE_HI     10
`define EAT_B_DIR         11
`define EAT_B_INDEX       12
`define EAT_B_SIDL        13
`define EAT_B_CERR        15
// filter register field
`define EAT_B_COUNT_ERROR_IRQ_DISABLE        8
// interrupt register fields
`define EAT_B_IFLAG       8
`define EAT_B_IEN         0
// reset values
`define EAT_RST_CTRL      16'h0000
`define EAT_RST_FILT      16'h0000
`define EAT_RST_POS       16'h0000
`define EAT_RST_MAX       16'hFFFF
`endif

//--- logic/eat_pkg.sv
package eat_pkg;
  typedef enum logic [2:0] {
    EAT_MODE_OFF0  = 3'h0,
    EAT_MODE_TIMER = 3'h1,
    EAT_MODE_OFF2  = 3'h2,
    EAT_MODE_OFF3  = 3'h3,
    EAT_MODE_IDX4  = 3'h4,
    EAT_MODE_MAT5  = 3'h5,
    EAT_MODE_IDX6  = 3'h6,
    EAT_MODE_MAT7  = 3'h7
  } eat_mode_t;

  typedef struct packed {
    logic phase_a;
    logic phase_b;
    logic index;
  } eat_pins_t;

  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } eat_bus_t;

  typedef struct packed {
    logic phase_a_own;
    logic phase_b_own;
    logic index_own;
    logic dir_own;
  } eat_own_t;
endpackage

//--- logic/eat_sync.sv
`timescale 1ns/100ps
module eat_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             core_clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // eat_sync

//--- verification/eat_enc_model.sv
`timescale 1ns/100ps
// ****************************************
// encoder and external clock source
// ****************************************
module eat_enc_model (
  input  wire logic        core_clk,
  output eat_pkg::eat_pins_t pins
);
  import eat_pkg::*;

  initial pins = '0;

  // rate limit: every level stands at least four core cycles
  task automatic hold();
    repeat (4) @(posedge core_clk);
  endtask

  task automatic set_b(input logic v);
    @(posedge core_clk);
    pins.phase_b <= v;
    hold();
  endtask

  // rate limit: one clock pulse spans nine core cycles
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge core_clk);
      pins.phase_a <= 1'b1;
      hold();
      pins.phase_a <= 1'b0;
      hold();
    end
  endtask

  // forward means phase A leads phase B
  task automatic quad(input int n, input logic fwd);
    repeat (n) begin
      @(posedge core_clk);
      if ((pins.phase_a == pins.phase_b) == fwd) begin
        pins.phase_a <= ~pins.phase_a;
      end else begin
        pins.phase_b <= ~pins.phase_b;
      end
      hold();
    end
  endtask

  task automatic index_pulse();
    @(posedge core_clk);
    pins.index <= 1'b1;
    hold();
    pins.index <= 1'b0;
    hold();
  endtask
endmodule // eat_enc_model

//--- verification/encoder_aux_timer_counter_tb_top.sv
`timescale 1ns/100ps
`include "eat_map.svh"
module encoder_aux_timer_counter_tb_top;
  import eat_pkg::*;

  logic        core_clk;
  logic        srst;
  logic        sleep;
  logic        idle;
  eat_bus_t    bus;
  eat_pins_t   pins;
  eat_own_t    own;
  logic [15:0] rdata;
  logic        dir_s;
  logic        irq;
  int          err_count;
  int          num_checks;

  eat_top dut (
    .core_clk         (core_clk),
    .srst             (srst),
    .bus              (bus),
    .rdata            (rdata),
    .pins             (pins),
    .sleep            (sleep),
    .idle             (idle),
    .own              (own),
    .direction_status (dir_s),
    .irq              (irq)
  );

  eat_enc_model src (
    .core_clk (core_clk),
    .pins     (pins)
  );

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // ****************************************
  // checks and bus cycles
  // ****************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    bus <= {a, d, 1'b1, 1'b0};
    @(posedge core_clk);
    bus <= '0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    bus <= {a, 16'h0000, 1'b0, 1'b1};
    @(posedge core_clk);
    bus <= '0;
    #1;
    chk(rdata, exp);
  endtask

  task automatic set_halt(input logic s, input logic i);
    @(posedge core_clk);
    sleep <= s;
    idle  <= i;
  endtask

  task automatic do_reset();
    srst <= 1'b1;
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk_reset();
    reg_rd(`EAT_IDX_CTRL, 16'h0000);
    reg_rd(`EAT_IDX_POS, 16'h0000);
    reg_rd(`EAT_IDX_MAX, 16'hFFFF);
    reg_rd(`EAT_IDX_IRQ, 16'h0000);
    chk({12'h000, own}, 16'h0000);
    chk({15'h0000, irq}, 16'h0000);
  endtask

  initial begin
    repeat (100000) @(posedge core_clk);
    err_count++;
    summarize();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    err_count = 0;
    num_checks = 0;
    bus = '0;
    {sleep, idle} = 2'b00;
    do_reset();
    chk_reset();
    reg_wr(4'hF, 16'hABCD);
    reg_rd(4'hF, 16'h0000);
    $display("test reset done");

    reg_wr(`EAT_IDX_MAX, 16'h0003);
    reg_wr(`EAT_IDX_IRQ, 16'h0001);
    reg_wr(`EAT_IDX_CTRL, 16'h0902);
    src.pulse(5);
    reg_rd(`EAT_IDX_POS, 16'h0001);
    reg_rd(`EAT_IDX_IRQ, 16'h0101);
    chk({15'h0000, irq}, 16'h0001);
    reg_wr(`EAT_IDX_IRQ, 16'h0001);
    reg_rd(`EAT_IDX_IRQ, 16'h0001);
    reg_wr(`EAT_IDX_CTRL, 16'h0102);
    reg_wr(`EAT_IDX_MAX, 16'hFFFD);
    reg_wr(`EAT_IDX_POS, 16'h0000);
    src.pulse(5);
    reg_rd(`EAT_IDX_POS, 16'hFFFF);
    $display("test timer wrap done");

    reg_wr(`EAT_IDX_MAX, 16'hFFFF);
    reg_wr(`EAT_IDX_POS, 16'h0000);
    src.set_b(1'b1);
    reg_wr(`EAT_IDX_CTRL, 16'h0103);
    src.pulse(3);
    reg_rd(`EAT_IDX_POS, 16'h0003);
    src.set_b(1'b0);
    src.pulse(2);
    reg_rd(`EAT_IDX_POS, 16'h0001);
    chk({15'h0000, own.phase_b_own}, 16'h0001);
    chk({15'h0000, own.index_own}, 16'h0000);
    set_halt(1'b1, 1'b0);
    src.pulse(3);
    reg_rd(`EAT_IDX_POS, 16'h0001);
    reg_rd(`EAT_IDX_CTRL, 16'h0103);
    set_halt(1'b0, 1'b0);
    src.set_b(1'b1);
    reg_wr(`EAT_IDX_CTRL, 16'h2103);
    set_halt(1'b0, 1'b1);
    src.pulse(2);
    reg_rd(`EAT_IDX_POS, 16'h0001);
    reg_wr(`EAT_IDX_CTRL, 16'h0103);
    src.pulse(2);
    reg_rd(`EAT_IDX_POS, 16'h0003);
    set_halt(1'b0, 1'b0);
    $display("test direction and halt done");

    reg_wr(`EAT_IDX_IRQ, 16'h0001);
    reg_wr(`EAT_IDX_CTRL, 16'h0922);
    src.pulse(2);
    reg_rd(`EAT_IDX_POS, 16'h0003);
    reg_rd(`EAT_IDX_IRQ, 16'h0101);
    reg_wr(`EAT_IDX_CTRL, 16'h0920);
    reg_wr(`EAT_IDX_IRQ, 16'h0001);
    repeat (10) @(posedge core_clk);
    reg_rd(`EAT_IDX_POS, 16'h0003);
    reg_rd(`EAT_IDX_IRQ, 16'h0001);
    src.pulse(1);
    reg_rd(`EAT_IDX_IRQ, 16'h0101);
    // synced phase A stands high for four core cycles of the pulse
    reg_rd(`EAT_IDX_POS, 16'h0007);
    $display("test gate done");

    for (int m = 0; m < 8; m++) begin
      if (m != 1) begin
        reg_wr(`EAT_IDX_CTRL, 16'(m) << 8 | 16'h0040);
        repeat (3) @(posedge core_clk);
        // modes 0, 2, 3 own nothing; index only in modes 4 and 6
        chk({12'h000, own}, (m < 4) ? 16'h0000 :
            (m[0] ? 16'h000D : 16'h000F));
      end
    end
    reg_wr(`EAT_IDX_CTRL, 16'h0500);
    repeat (3) @(posedge core_clk);
    chk({12'h000, own}, 16'h000C);
    $display("test pin ownership done");

    src.set_b(1'b0);
    reg_wr(`EAT_IDX_CTRL, 16'h0740);
    reg_wr(`EAT_IDX_MAX, 16'h0003);
    reg_wr(`EAT_IDX_POS, 16'h0000);
    reg_wr(`EAT_IDX_IRQ, 16'h0001);
    src.quad(5, 1'b1);
    reg_rd(`EAT_IDX_POS, 16'h0001);
    reg_rd(`EAT_IDX_IRQ, 16'h0101);
    chk({15'h0000, dir_s}, 16'h0001);
    src.quad(1, 1'b0);
    reg_rd(`EAT_IDX_POS, 16'h0000);
    chk({15'h0000, dir_s}, 16'h0000);
    reg_wr(`EAT_IDX_CTRL, 16'h0640);
    reg_wr(`EAT_IDX_IRQ, 16'h0001);
    src.index_pulse();
    reg_rd(`EAT_IDX_IRQ, 16'h0101);
    // index reload left the count at the period; one up step overruns it
    reg_wr(`EAT_IDX_IRQ, 16'h0001);
    src.quad(1, 1'b1);
    reg_rd(`EAT_IDX_CTRL, 16'h8E40);
    reg_rd(`EAT_IDX_IRQ, 16'h0101);
    reg_wr(`EAT_IDX_IRQ, 16'h0100);
    #1;
    chk({15'h0000, irq}, 16'h0000);
    $display("test encoder events done");

    do_reset();
    chk_reset();
    $display("test second reset done");
    summarize();
  end
endmodule // encoder_aux_timer_counter_tb_top
